// >>> core/atc_pkg.sv
// Shared constants and types for the acquisition trigger control block
package atc_pkg;
   // Register byte addresses
   localparam logic [7:0] ATC_CTRL  = 8'h00;
   localparam logic [7:0] ATC_WIDTH = 8'h04;
   localparam logic [7:0] ATC_DELAY = 8'h08;
   localparam logic [7:0] ATC_HOLD  = 8'h0c;
   localparam logic [7:0] ATC_PRE   = 8'h10;
   localparam logic [7:0] ATC_POST  = 8'h14;
   localparam logic [7:0] ATC_MEM   = 8'h18;
   localparam logic [7:0] ATC_SEG   = 8'h1c;
   localparam logic [7:0] ATC_STAT  = 8'h20;
   localparam logic [7:0] ATC_TPOS  = 8'h24;
   // Control field positions
   localparam int EDGE_LSB  = 0;
   localparam int SRC_LSB   = 2;
   localparam int MODE_LSB  = 4;
   localparam int START_BIT = 8;
   localparam int STOP_BIT  = 9;
   localparam int CHLOG_LSB = 12;
   localparam logic [31:0] CTRL_MASK = 32'h0000_707f;
   // Reset values; length registers count blocks of eight samples
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST = 32'h0000_0000;
   localparam logic [29:0] PRE_RST   = 30'h0000_0001;
   localparam logic [29:0] POST_RST  = 30'h0000_0001;
   localparam logic [29:0] MEM_RST   = 30'h0000_0002;
   localparam logic [29:0] SEG_RST   = 30'h0000_0002;
   // 32 kSamples of pretrigger storage, in blocks of eight
   localparam logic [29:0] PRE_MAX_BLOCKS = 30'h0000_1000;
   localparam logic [2:0]  CHLOG_MAX      = 3'h4;
   localparam int          REARM_LIMIT    = 24;

   typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} atc_edge_t;
   typedef enum logic [2:0] {
      MODE_SINGLE, MODE_SEGMENTED, MODE_DUAL_RATE, MODE_GATED, MODE_STREAM
   } atc_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PRE, ST_ARMED, ST_DELAY, ST_POST, ST_HOLD
   } atc_state_t;
endpackage

// >>> core/atc_trig_qual.sv
// Edge and pulse-width qualifier for the selected trigger source
`timescale 1ns/100ps
module atc_trig_qual (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        src_i,
   input  wire logic [1:0]  edge_i,
   input  wire logic [31:0] width_i,
   output logic             fire_o
);
   logic        prev, pend, lvl, edge_hit;
   logic        next_prev, next_pend, next_lvl, next_fire;
   logic [31:0] wcnt, next_wcnt;

   always_comb begin
      case (edge_i)
         atc_pkg::EDGE_RISE: edge_hit = src_i & ~prev;
         atc_pkg::EDGE_FALL: edge_hit = ~src_i & prev;
         atc_pkg::EDGE_BOTH: edge_hit = src_i ^ prev;
         default:            edge_hit = 1'b0;
      endcase
   end

   always_comb begin
      next_prev = src_i;
      next_fire = 1'b0;
      next_pend = pend;
      next_lvl  = lvl;
      next_wcnt = wcnt;
      if (edge_hit) begin
         // A fresh edge restarts any width check in progress
         if (width_i == 32'h0) begin
            next_fire = 1'b1;
         end else begin
            next_pend = 1'b1;
            next_lvl  = src_i;
            next_wcnt = 32'h1;
         end
      end else if (pend) begin
         if (src_i != lvl) begin
            next_pend = 1'b0;
         end else if (wcnt >= width_i) begin
            next_fire = 1'b1;
            next_pend = 1'b0;
         end else begin
            next_wcnt = wcnt + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev   <= 1'b0;
         pend   <= 1'b0;
         lvl    <= 1'b0;
         wcnt   <= atc_pkg::COUNT_RST;
         fire_o <= 1'b0;
      end else begin
         prev   <= next_prev;
         pend   <= next_pend;
         lvl    <= next_lvl;
         wcnt   <= next_wcnt;
         fire_o <= next_fire;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence rise_held2;
      (edge_i == atc_pkg::EDGE_RISE && width_i == 32'h2 && src_i && !prev)
      ##1 (src_i && $stable(width_i) && $stable(edge_i)) [*2];
   endsequence

   edge_rise_a: assert property (
      (edge_i == atc_pkg::EDGE_RISE && width_i == 32'h0 && src_i && !prev)
      |=> fire_o) else $error("rising edge not fired");
   edge_fall_a: assert property (
      (edge_i == atc_pkg::EDGE_FALL && width_i == 32'h0 && !src_i && prev)
      |=> fire_o) else $error("falling edge not fired");
   rise_quiet_a: assert property (
      (edge_i == atc_pkg::EDGE_RISE && $stable(edge_i) && !src_i)
      |=> !fire_o) else $error("fire with rising source low");
   width_hold_a: assert property (
      rise_held2 |=> fire_o) else $error("width qualified pulse missed");
endmodule // atc_trig_qual

// >>> core/atc_trigger_control.sv
// Trigger qualification and acquisition sequencer with Wishbone registers
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module atc_trigger_control (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_trig_i,
   input  wire logic        multipurpose_line_one_i,
   input  wire logic        multipurpose_line_two_i,
   input  wire logic        multipurpose_line_three_i,
   output logic             store_o,
   output logic             trig_mark_o,
   output logic             seg_end_o,
   output logic             slow_rate_o,
   output logic             busy_o
);
   logic [31:0] ctrl, pw, dly, hold, rd_val, wmerged;
   logic [31:0] next_ctrl, next_pw, next_dly, next_hold, next_rdat;
   logic [29:0] pre_b, post_b, mem_b, seg_b;
   logic [29:0] next_pre_b, next_post_b, next_mem_b, next_seg_b;
   logic        next_ack, start_p, stop_p, wr;

   // Two-flop synchronisers for the asynchronous trigger pins
   logic [3:0] pins, sync1, sync2;
   logic       src, qual_p;
   assign pins = {multipurpose_line_three_i, multipurpose_line_two_i,
                  multipurpose_line_one_i, ext_trig_i};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pins[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate
   assign src = sync2[ctrl[atc_pkg::SRC_LSB +: 2]];

   atc_trig_qual u_qual (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .src_i   (src),
      .edge_i  (ctrl[atc_pkg::EDGE_LSB +: 2]),
      .width_i (pw),
      .fire_o  (qual_p)
   );

   // Effective lengths in blocks of eight samples; pre_len and post_len in samples
   atc_pkg::atc_mode_t mode;
   logic [2:0]  chlog;
   logic [29:0] pre_max, pre_eff, post_eff, mem_eff, seg_eff;
   logic [29:0] pre_len_b, post_len_b;
   logic [32:0] pre_len, post_len;
   logic        holdoff_mode, multi_mode;
   assign mode  = atc_pkg::atc_mode_t'(ctrl[atc_pkg::MODE_LSB +: 3]);
   assign chlog = (ctrl[atc_pkg::CHLOG_LSB +: 3] > atc_pkg::CHLOG_MAX) ?
                  atc_pkg::CHLOG_MAX : ctrl[atc_pkg::CHLOG_LSB +: 3];
   assign pre_max = atc_pkg::PRE_MAX_BLOCKS >> chlog;
   assign pre_eff = (pre_b == 30'h0) ? 30'h1 :
                    (pre_b > pre_max) ? pre_max : pre_b;
   assign post_eff = (post_b == 30'h0) ? 30'h1 : post_b;
   assign mem_eff  = (mem_b == 30'h0) ? 30'h1 : mem_b;
   assign seg_eff  = (seg_b == 30'h0) ? 30'h1 : seg_b;
   assign holdoff_mode = (mode == atc_pkg::MODE_SEGMENTED) ||
                         (mode == atc_pkg::MODE_DUAL_RATE) ||
                         (mode == atc_pkg::MODE_GATED);
   assign multi_mode = (mode == atc_pkg::MODE_SEGMENTED) ||
                       (mode == atc_pkg::MODE_DUAL_RATE);

   always_comb begin
      case (mode)
         atc_pkg::MODE_SEGMENTED, atc_pkg::MODE_DUAL_RATE: begin
            // Segment holds pretrigger and posttrigger together
            pre_len_b  = (seg_eff > pre_eff) ? pre_eff : seg_eff - 30'h1;
            post_len_b = (seg_eff > pre_eff) ? seg_eff - pre_eff : 30'h1;
         end
         atc_pkg::MODE_GATED, atc_pkg::MODE_STREAM: begin
            pre_len_b  = pre_eff;
            post_len_b = post_eff;
         end
         default: begin
            pre_len_b  = (mem_eff > post_eff) ? mem_eff - post_eff : 30'h0;
            post_len_b = post_eff;
         end
      endcase
   end
   assign pre_len  = {pre_len_b, 3'h0};
   assign post_len = {post_len_b, 3'h0};

   // Sequencer state
   atc_pkg::atc_state_t state, next_state;
   logic [32:0] cnt, next_cnt;
   logic [31:0] samp, next_samp, tpos, next_tpos;
   logic [29:0] used_b, next_used, used_nx;
   logic [15:0] segc, next_segc;
   logic        done, next_done, next_mark, next_end, rearm;
   assign used_nx = used_b + seg_eff;

   always_comb begin
      case (wb_adr_i)
         atc_pkg::ATC_CTRL:  rd_val = ctrl;
         atc_pkg::ATC_WIDTH: rd_val = pw;
         atc_pkg::ATC_DELAY: rd_val = dly;
         atc_pkg::ATC_HOLD:  rd_val = hold;
         atc_pkg::ATC_PRE:   rd_val = {2'h0, pre_b};
         atc_pkg::ATC_POST:  rd_val = {2'h0, post_b};
         atc_pkg::ATC_MEM:   rd_val = {2'h0, mem_b};
         atc_pkg::ATC_SEG:   rd_val = {2'h0, seg_b};
         atc_pkg::ATC_STAT:  rd_val = {segc, 12'h0, done, state};
         atc_pkg::ATC_TPOS:  rd_val = tpos;
         default:            rd_val = 32'h0;
      endcase
   end

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmerged[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] :
                             rd_val[8*b +: 8];
      end
   end

   // Write lands on the edge where the master sees ack
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   always_comb begin
      next_ack    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_rdat   = wb_dat_o;
      next_ctrl   = ctrl;
      next_pw     = pw;
      next_dly    = dly;
      next_hold   = hold;
      next_pre_b  = pre_b;
      next_post_b = post_b;
      next_mem_b  = mem_b;
      next_seg_b  = seg_b;
      start_p     = 1'b0;
      stop_p      = 1'b0;
      if (next_ack && !wb_we_i) begin
         next_rdat = rd_val;
      end
      if (wr) begin
         case (wb_adr_i)
            atc_pkg::ATC_CTRL: begin
               next_ctrl = wmerged & atc_pkg::CTRL_MASK;
               start_p   = wb_sel_i[1] & wb_dat_i[atc_pkg::START_BIT];
               stop_p    = wb_sel_i[1] & wb_dat_i[atc_pkg::STOP_BIT];
            end
            atc_pkg::ATC_WIDTH: next_pw     = wmerged;
            atc_pkg::ATC_DELAY: next_dly    = wmerged;
            atc_pkg::ATC_HOLD:  next_hold   = wmerged;
            atc_pkg::ATC_PRE:   next_pre_b  = wmerged[29:0];
            atc_pkg::ATC_POST:  next_post_b = wmerged[29:0];
            atc_pkg::ATC_MEM:   next_mem_b  = wmerged[29:0];
            atc_pkg::ATC_SEG:   next_seg_b  = wmerged[29:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_mark  = 1'b0;
      next_end   = 1'b0;
      next_done  = done;
      next_segc  = segc;
      next_used  = used_b;
      next_tpos  = tpos;
      next_samp  = samp + 32'h1;
      rearm      = 1'b0;
      case (state)
         atc_pkg::ST_IDLE: begin
            if (start_p) begin
               next_done = 1'b0;
               next_segc = 16'h0;
               next_used = 30'h0;
               rearm     = 1'b1;
            end
         end
         atc_pkg::ST_PRE: begin
            // No trigger is taken until the pretrigger has filled
            if (cnt <= 33'h1) next_state = atc_pkg::ST_ARMED;
            else next_cnt = cnt - 33'h1;
         end
         atc_pkg::ST_ARMED: begin
            if (qual_p) begin
               if (dly == 32'h0) begin
                  next_state = atc_pkg::ST_POST;
                  next_cnt   = post_len;
                  next_mark  = 1'b1;
                  next_tpos  = samp + 32'h1;
               end else begin
                  next_state = atc_pkg::ST_DELAY;
                  next_cnt   = {1'b0, dly};
               end
            end
         end
         atc_pkg::ST_DELAY: begin
            if (cnt <= 33'h1) begin
               next_state = atc_pkg::ST_POST;
               next_cnt   = post_len;
               next_mark  = 1'b1;
               next_tpos  = samp + 32'h1;
            end else next_cnt = cnt - 33'h1;
         end
         atc_pkg::ST_POST: begin
            if (cnt <= 33'h1) begin
               next_end  = 1'b1;
               next_segc = segc + 16'h1;
               next_used = used_nx;
               if (mode == atc_pkg::MODE_SINGLE || (multi_mode &&
                   ({1'b0, used_nx} + {1'b0, seg_eff}) > {1'b0, mem_eff}))
               begin
                  next_state = atc_pkg::ST_IDLE;
                  next_done  = 1'b1;
               end else if (holdoff_mode && hold != 32'h0) begin
                  next_state = atc_pkg::ST_HOLD;
                  next_cnt   = {1'b0, hold};
               end else rearm = 1'b1;
            end else next_cnt = cnt - 33'h1;
         end
         atc_pkg::ST_HOLD: begin
            if (cnt <= 33'h1) rearm = 1'b1;
            else next_cnt = cnt - 33'h1;
         end
         default: next_state = atc_pkg::ST_IDLE;
      endcase
      if (rearm) begin
         next_state = (pre_len == 33'h0) ? atc_pkg::ST_ARMED : atc_pkg::ST_PRE;
         next_cnt   = pre_len;
      end
      if (stop_p && state != atc_pkg::ST_IDLE) begin
         // A mark in the stop cycle would point at no recorded sample
         next_state = atc_pkg::ST_IDLE;
         next_done  = 1'b1;
         next_mark  = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= atc_pkg::CTRL_RST;   pw     <= atc_pkg::COUNT_RST;
         dly  <= atc_pkg::COUNT_RST;  hold   <= atc_pkg::COUNT_RST;
         pre_b <= atc_pkg::PRE_RST;   post_b <= atc_pkg::POST_RST;
         mem_b <= atc_pkg::MEM_RST;   seg_b  <= atc_pkg::SEG_RST;
         wb_ack_o <= 1'b0;            wb_dat_o <= 32'h0;
      end else begin
         ctrl <= next_ctrl;           pw     <= next_pw;
         dly  <= next_dly;            hold   <= next_hold;
         pre_b <= next_pre_b;         post_b <= next_post_b;
         mem_b <= next_mem_b;         seg_b  <= next_seg_b;
         wb_ack_o <= next_ack;        wb_dat_o <= next_rdat;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= atc_pkg::ST_IDLE;   cnt <= 33'h0;
         samp <= 32'h0;               tpos <= 32'h0;
         used_b <= 30'h0;             segc <= 16'h0;
         done <= 1'b0;                trig_mark_o <= 1'b0;
         seg_end_o <= 1'b0;           store_o <= 1'b0;
         slow_rate_o <= 1'b0;         busy_o <= 1'b0;
      end else begin
         state <= next_state;         cnt <= next_cnt;
         samp <= next_samp;           tpos <= next_tpos;
         used_b <= next_used;         segc <= next_segc;
         done <= next_done;           trig_mark_o <= next_mark;
         seg_end_o <= next_end;
         store_o <= next_state inside {atc_pkg::ST_PRE, atc_pkg::ST_ARMED,
                    atc_pkg::ST_DELAY, atc_pkg::ST_POST};
         slow_rate_o <= mode == atc_pkg::MODE_DUAL_RATE &&
                        next_state == atc_pkg::ST_HOLD;
         busy_o <= next_state != atc_pkg::ST_IDLE;
      end
   end

   // Helper: samples spent re-arming since the last segment
   localparam logic [33:0] REARM_LIM = 34'(atc_pkg::REARM_LIMIT);
   logic [33:0] rc;
   always_ff @(posedge clk_i) begin
      if (rst_i) rc <= 34'h0;
      else if (next_state inside {atc_pkg::ST_HOLD, atc_pkg::ST_PRE})
         rc <= rc + 34'h1;
      else rc <= 34'h0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence arm_take3;
      state == atc_pkg::ST_ARMED && qual_p && dly == 32'h3 && !stop_p;
   endsequence
   sequence post_eight;
      trig_mark_o && cnt == 33'h8;
   endsequence

   mark_once_a: assert property (trig_mark_o |=> !trig_mark_o)
      else $error("trigger mark longer than one sample");
   mark_post_a: assert property (
      trig_mark_o |-> store_o && state == atc_pkg::ST_POST && tpos == samp)
      else $error("trigger mark outside posttrigger start");
   hold_mode_a: assert property (
      state == atc_pkg::ST_HOLD |-> holdoff_mode)
      else $error("holdoff in wrong mode");
   hold_block_a: assert property (
      state == atc_pkg::ST_HOLD |=> !trig_mark_o)
      else $error("trigger accepted during holdoff");
   rearm_time_a: assert property (
      rc != 34'h0 |-> rc < REARM_LIM + {1'b0, pre_len} + {2'h0, hold})
      else $error("re-arm too slow");
   pre_range_a: assert property (
      pre_eff != 30'h0 && pre_eff <= pre_max && pre_max <= 30'h1000)
      else $error("pretrigger out of range");
   post_len_a: assert property (post_eight |-> ##8 seg_end_o)
      else $error("posttrigger length wrong");
   single_pre_a: assert property (
      (mode == atc_pkg::MODE_SINGLE && mem_eff > post_eff)
      |-> pre_len == {mem_eff - post_eff, 3'h0})
      else $error("single shot pretrigger wrong");
   depth_min_a: assert property (
      mem_eff != 30'h0 && seg_eff != 30'h0 && post_len[2:0] == 3'h0)
      else $error("depth or segment below one block");
   line_sel_a: assert property (
      (ctrl[3:2] == 2'h1 && $stable(ctrl))
      |-> src == $past(multipurpose_line_one_i, 2))
      else $error("line one not routed to trigger");
   delay_a: assert property (arm_take3 |-> ##4 trig_mark_o)
      else $error("trigger delay wrong");
endmodule // atc_trigger_control

// >>> test/atc_far_side.sv
// Far-side model: trigger sources and a counter of sample store strobes
`timescale 1ns/100ps
module atc_far_side (
   input  wire logic        clk_i,
   input  wire logic        clr_i,
   input  wire logic [1:0]  sel_i,
   input  wire logic        lvl_i,
   input  wire logic        store_i,
   output logic             ext_trig_o,
   output logic             line_one_o,
   output logic             line_two_o,
   output logic             line_three_o,
   output logic      [31:0] stores_o
);
   logic [31:0] next_stores;
   // Unselected sources idle low so a wrong route never fires
   assign ext_trig_o   = (sel_i == 2'h0) & lvl_i;
   assign line_one_o   = (sel_i == 2'h1) & lvl_i;
   assign line_two_o   = (sel_i == 2'h2) & lvl_i;
   assign line_three_o = (sel_i == 2'h3) & lvl_i;
   always_comb begin
      next_stores = clr_i ? 32'h0 : stores_o + {31'h0, store_i};
   end
   always_ff @(posedge clk_i) begin
      stores_o <= next_stores;
   end
endmodule // atc_far_side

// >>> test/atc_trigger_control_test.sv
// Self-checking bench for the acquisition trigger control block
`timescale 1ns/100ps
module atc_trigger_control_test;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'hf;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] rdat, dat_o, stores;
   logic        ack, ext, l1, l2, l3, store, mark, seg_end, slow, busy;
   logic        lvl = 1'b0;
   logic        tog = 1'b0;
   logic        clr = 1'b1;
   logic [1:0]  src = 2'h0;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          seed = 32'h5775;

   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (tog) lvl <= ~lvl;

   atc_trigger_control u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_trig_i(ext),
      .multipurpose_line_one_i(l1), .multipurpose_line_two_i(l2),
      .multipurpose_line_three_i(l3), .store_o(store),
      .trig_mark_o(mark), .seg_end_o(seg_end), .slow_rate_o(slow),
      .busy_o(busy));
   atc_far_side u_far (.clk_i(clk_i), .clr_i(clr), .sel_i(src),
      .lvl_i(lvl), .store_i(store), .ext_trig_o(ext), .line_one_o(l1),
      .line_two_o(l2), .line_three_o(l3), .stores_o(stores));

   task automatic summarize();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Whole run needs well under ten thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      total_checks++;
      if (n < lo || n > hi) begin
         miscompares++;
         $display("[FAIL] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
      end
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = dat_o;
      if (n >= 50) chk_rng(n, 0, 49);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic wait_mark(output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (mark !== 1'b1 && n < 400);
   endtask
   task automatic quiet(input int k);
      int q;
      q = 0;
      repeat (k) begin
         @(posedge clk_i);
         if (mark !== 1'b0) q++;
      end
      chk_rng(q, 0, 0);
   endtask

   function automatic int mark_lat(input int w, input int d);
      return 5 + w + d;
   endfunction
   function automatic logic [31:0] ctrl(input int e, s, m);
      return (e << atc_pkg::EDGE_LSB) | (s << atc_pkg::SRC_LSB) |
             (m << atc_pkg::MODE_LSB) | (1 << atc_pkg::START_BIT);
   endfunction

   initial begin
      int n, w, d, h, e, s, m, hold;
      int tm [3] = '{3, 2, 2};
      int tp [3] = '{1, 3, 0};
      int te [3] = '{16, 0, 8};
      logic [31:0] v;
      idle(5);
      rst_i <= 1'b0;
      clr <= 1'b0;
      idle(1);
      rd(atc_pkg::ATC_CTRL, 32'h0);
      rd(atc_pkg::ATC_WIDTH, 32'h0);
      rd(atc_pkg::ATC_PRE, 32'h1);
      rd(atc_pkg::ATC_POST, 32'h1);
      rd(atc_pkg::ATC_MEM, 32'h2);
      rd(atc_pkg::ATC_SEG, 32'h2);
      rd(8'h28, 32'h0);
      v = $random(seed);
      wr(atc_pkg::ATC_HOLD, v);
      rd(atc_pkg::ATC_HOLD, v);
      wr(atc_pkg::ATC_DELAY, 32'hffff_ffff);
      rd(atc_pkg::ATC_DELAY, 32'hffff_ffff);
      for (e = 0; e < 3; e++) for (s = 0; s < 4; s++) begin
         w = {$random(seed)} % 4;
         d = {$random(seed)} % 4;
         wr(atc_pkg::ATC_WIDTH, w);
         wr(atc_pkg::ATC_DELAY, d);
         src <= s[1:0];
         lvl <= (e == 0);
         idle(6);
         wr(atc_pkg::ATC_CTRL, ctrl(e, s, 0));
         idle(10);
         // Opposite edge first: must be ignored
         if (e != 2) begin
            lvl <= (e == 1);
            quiet(12);
            lvl <= (e == 0);
         end else lvl <= ~lvl;
         wait_mark(n);
         chk_rng(n, mark_lat(w, d), mark_lat(w, d));
         idle(1);
         chk({31'h0, mark}, 32'h0);
         idle(7);
         chk({31'h0, seg_end}, 32'h1);
         idle(2);
         rd(atc_pkg::ATC_STAT, 32'h0001_0008);
      end
      wr(atc_pkg::ATC_WIDTH, 32'h3);
      wr(atc_pkg::ATC_DELAY, 32'h0);
      src <= 2'h0;
      lvl <= 1'b0;
      idle(6);
      wr(atc_pkg::ATC_CTRL, ctrl(0, 0, 0));
      idle(10);
      lvl <= 1'b1;
      idle(2);
      lvl <= 1'b0;
      quiet(20);
      lvl <= 1'b1;
      wait_mark(n);
      chk_rng(n, mark_lat(3, 0), mark_lat(3, 0));
      idle(12);
      wr(atc_pkg::ATC_WIDTH, 32'h0);
      for (m = 0; m < 3; m++) begin
         wr(atc_pkg::ATC_MEM, tm[m]);
         wr(atc_pkg::ATC_POST, tp[m]);
         clr <= 1'b1;
         tog <= 1'b1;
         idle(1);
         clr <= 1'b0;
         wr(atc_pkg::ATC_CTRL, ctrl(2, 0, 0));
         wait_mark(n);
         chk_rng(stores, te[m], te[m] + 3);
         tog <= 1'b0;
         idle(30);
      end
      wr(atc_pkg::ATC_PRE, 32'h1);
      wr(atc_pkg::ATC_POST, 32'h1);
      wr(atc_pkg::ATC_SEG, 32'h2);
      wr(atc_pkg::ATC_MEM, 32'h8);
      for (m = 1; m < 5; m++) begin
         h = 50 + {$random(seed)} % 20;
         hold = (m == 4) ? 0 : h;
         wr(atc_pkg::ATC_HOLD, h);
         tog <= 1'b1;
         wr(atc_pkg::ATC_CTRL, ctrl(2, 0, m));
         wait_mark(n);
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (seg_end !== 1'b1 && n < 400);
         chk_rng(n, 8, 8);
         idle(3);
         chk({31'h0, slow}, {31'h0, m == 2});
         wait_mark(n);
         chk_rng(n + 3, hold, 24 + 8 + hold + 5);
         tog <= 1'b0;
         // Let the posttrigger finish so the segment end is seen
         idle(8);
         wr(atc_pkg::ATC_CTRL, 32'h1 << atc_pkg::STOP_BIT);
         idle(2);
         chk({31'h0, busy}, 32'h0);
      end
      summarize();
   end
endmodule // atc_trigger_control_test
